// ---- tcm_control_unit.sv ----
// Tape control unit: mode selection, channel arbitration, sense bytes and diagnostics.
// Operation
// - Eight drives without switching options.
// - Single density reads and writes PE only.
// - Dual density gives PE and nine-track NRZI.
// - Seven-track gives NRZI, both densities and formats.
// - Host mode-sets before first dual-density write.
// - PE write at load point records ID burst.
// - Burst seen on read selects PE.
// - No burst, both dual, selects NRZI.
// - NRZI read without dual density errors.
// - Read mode kept until load point.
// - One seven-track mode set applies everything.
// - Switching extends reach to sixteen drives.
// - Communicator needed for remote drives.
// - Switched unit runs two operations concurrently.
// - Unswitched, one channel at a time; other waits.
// - Reserve gives exclusivity until same-channel release.
// - Partitioned drive refuses the other channel.
// - Twenty sense bytes with trace and identity.
// - Diagnostic command runs resident diagnostics.
// - Measurement faults set sense bits.
// - Density options are mutually exclusive.
`timescale 1ns/1ps
module tcm_control_unit
  import tcm_pkg::*;
#(
  parameter logic [15:0] CU_SERIAL = 16'h1234,  // Arbitrary value.
  parameter logic [7:0] EC_LEVEL = 8'h01,       // Arbitrary value.
  parameter int DIAG_LEN = DIAG_CYCLES
)
(
  input logic core_clk,
  input logic rstn,
  tcm_if.dev link,
  input tcm_opt_t cuOption,
  input tcm_opt_t driveOption [NUM_DRIVES],
  input logic switchInstalled,
  input logic communicatorInstalled,
  input logic [NUM_DRIVES-1:0] partitionEnable,
  input logic [NUM_DRIVES-1:0] partitionChan,
  input logic [NUM_DRIVES-1:0] atLoadPoint,
  input logic [NUM_DRIVES-1:0] burstSensed,
  input logic [NUM_DRIVES-1:0] opDone,
  input logic [NUM_DRIVES-1:0] measureFault,
  input logic diagPass,
  output logic driveStart,
  output logic [DRV_W-1:0] driveSel,
  output logic driveWrite,
  output tcm_mode_t driveMode,
  output logic [SEVEN_W-1:0] sevenCfg,
  output logic writeIdBurst,
  output logic diagRunning
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  tcm_mode_t mode_reg [NUM_DRIVES];
  logic [SEVEN_W-1:0] seven_reg [NUM_DRIVES];
  logic [NUM_DRIVES-1:0] lpPrev_reg;
  logic [1:0] actValid_reg;
  logic [DRV_W-1:0] actDrive_reg [2];
  logic resvValid_reg;
  logic resvChan_reg;
  logic [FLG_W-1:0] flags_reg;
  logic [NUM_DRIVES-1:0] fault_reg;
  logic [DIAG_W-1:0] diagCnt_reg;
  logic [3:0] lastCmd_reg;
  logic [DRV_W-1:0] lastDrv_reg;
  logic respValid_reg;
  tcm_stat_t respStatus_reg;
  logic [ARG_W-1:0] respData_reg;

  logic [DRV_W-1:0] d;
  logic ch;
  logic take;
  logic otherResv;
  logic busy;
  logic access;
  tcm_stat_t stat;
  logic [ARG_W-1:0] data;
  logic startOp;
  logic setMode;
  tcm_mode_t newMode;
  tcm_mode_t opMode;
  logic burst;
  logic [FLG_W-1:0] flagSet;
  logic resvSet;
  logic resvClr;
  logic diagStart;
  logic senseClr;
  logic [ARG_W-1:0] senseArr [SENSE_BYTES];

  // Reachable drive: remote drives need both switching and the communicator.
  function automatic logic reachable(input logic [DRV_W-1:0] drv, input logic sw,
                                     input logic comm);
    reachable = (drv < BASE_DRIVES_V) || (sw && comm);
  endfunction

  assign d = link.cmdDrive;
  assign ch = link.cmdChan;
  assign take = link.cmdValid;
  assign link.cmdReady = 1'b1;
  assign diagRunning = (diagCnt_reg != '0);

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  // A reservation by the other channel makes the unit busy to this channel for every drive.
  always_comb
  begin
    otherResv = resvValid_reg && (resvChan_reg != ch);
    // Without switching, a second channel waits even for a different drive.
    busy = diagRunning || actValid_reg[ch] || otherResv ||
           (actValid_reg[~ch] && (!switchInstalled || actDrive_reg[~ch] == d));
    access = reachable(d, switchInstalled, communicatorInstalled) &&
             !(partitionEnable[d] && partitionChan[d] != ch) &&
             (cuOption == driveOption[d]) && (cuOption != OPT_NONE);
    stat = ST_OK;
    data = '0;
    startOp = 1'b0;
    setMode = 1'b0;
    newMode = MODE_UNSET;
    opMode = mode_reg[d];
    burst = 1'b0;
    flagSet = '0;
    resvSet = 1'b0;
    resvClr = 1'b0;
    diagStart = 1'b0;
    senseClr = 1'b0;
    case (link.cmdCode)
      CMD_SENSE:
      begin
        if (otherResv)
          stat = ST_BUSY;
        else if (link.cmdArg >= SENSE_BYTES_V)
          stat = ST_REJECT;
        else
        begin
          stat = ST_DATA;
          data = senseArr[link.cmdArg[4:0]];
          senseClr = (link.cmdArg == ARG_W'(SNS_FLAGS));
        end
      end
      CMD_RESERVE:
      begin
        if (otherResv || actValid_reg[~ch])
          stat = ST_BUSY;
        else
          resvSet = 1'b1;
      end
      CMD_RELEASE:
      begin
        if (otherResv)
          stat = ST_BUSY;
        else
          resvClr = 1'b1;
      end
      CMD_DIAG:
      begin
        if (busy || actValid_reg[~ch])
          stat = ST_BUSY;
        else
          diagStart = 1'b1;
      end
      CMD_MODE_SET, CMD_READ, CMD_WRITE:
      begin
        if (busy)
          stat = ST_BUSY;
        else if (!access)
        begin
          stat = ST_REJECT;
          flagSet[FLG_REJECT] = 1'b1;
        end
        else if (link.cmdCode == CMD_MODE_SET)
        begin
          // Each density option accepts only its own recording modes.
          if (cuOption == OPT_SINGLE && !link.cmdArg[ARG_NRZI])
            newMode = MODE_PE;
          else if (cuOption == OPT_DUAL)
            newMode = link.cmdArg[ARG_NRZI] ? MODE_NRZI9 : MODE_PE;
          else if (cuOption == OPT_SEVEN && link.cmdArg[ARG_NRZI])
            newMode = MODE_NRZI7;
          if (newMode == MODE_UNSET)
          begin
            stat = ST_REJECT;
            flagSet[FLG_MODE_REJ] = 1'b1;
          end
          else
            setMode = 1'b1;
        end
        else if (link.cmdCode == CMD_WRITE)
        begin
          if (cuOption == OPT_SINGLE)
            opMode = MODE_PE;
          if (opMode == MODE_UNSET)
          begin
            stat = ST_REJECT;
            flagSet[FLG_REJECT] = 1'b1;
          end
          else
          begin
            startOp = 1'b1;
            burst = (opMode == MODE_PE) && atLoadPoint[d];
          end
        end
        else
        begin
          // Reads starting at load point choose their format from the tape.
          if (atLoadPoint[d])
          begin
            if (burstSensed[d])
              opMode = MODE_PE;
            else if (cuOption == OPT_DUAL)
              opMode = MODE_NRZI9;
            else if (cuOption == OPT_SINGLE)
              opMode = MODE_UNSET;
          end
          else if (cuOption == OPT_SINGLE)
            opMode = MODE_PE;
          if (opMode == MODE_UNSET)
          begin
            stat = ST_ERROR;
            flagSet[FLG_ERROR] = 1'b1;
          end
          else
          begin
            startOp = 1'b1;
            setMode = 1'b1;
            newMode = opMode;
          end
        end
      end
      default:
        stat = ST_OK;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Sense bytes
  // ---------------------------------------------------------------------------
  // Bytes without a defined meaning read as zero.
  always_comb
  begin
    for (int i = 0; i < SENSE_BYTES; i++)
      senseArr[i] = '0;
    senseArr[SNS_FLAGS] = {3'h0, (fault_reg != '0), flags_reg};
    senseArr[SNS_MODE] = {6'h00, mode_reg[lastDrv_reg]};
    senseArr[SNS_TRACE] = {4'h0, lastCmd_reg};                          // microprogram_store trace
    senseArr[SNS_CU_SER_HI] = CU_SERIAL[15:8];
    senseArr[SNS_CU_SER_LO] = CU_SERIAL[7:0];
    senseArr[SNS_CU_OPT] = {4'h0, switchInstalled, communicatorInstalled, cuOption};
    senseArr[SNS_DRV_OPT] = {6'h00, driveOption[lastDrv_reg]};
    senseArr[SNS_EC_LEVEL] = EC_LEVEL;                                  // engineering_change_level
    senseArr[SNS_FAULT_LO] = fault_reg[7:0];
    senseArr[SNS_FAULT_HI] = fault_reg[15:8];
    senseArr[SNS_LAST_DRV] = {4'h0, lastDrv_reg};
  end

  // ---------------------------------------------------------------------------
  // Per-drive mode memory
  // ---------------------------------------------------------------------------
  // A return to load point forgets the mode; a command in that cycle wins.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_DRIVES; i++)
      begin
        mode_reg[i] <= MODE_UNSET;
        seven_reg[i] <= '0;
      end
      lpPrev_reg <= '0;
    end
    else
    begin
      lpPrev_reg <= atLoadPoint;
      for (int i = 0; i < NUM_DRIVES; i++)
        if (atLoadPoint[i] && !lpPrev_reg[i])
          mode_reg[i] <= MODE_UNSET;
      if (take && setMode)
        mode_reg[d] <= newMode;
      if (take && setMode && link.cmdCode == CMD_MODE_SET)
        seven_reg[d] <= link.cmdArg[ARG_CONV:ARG_DENS];
    end
  end

  // ---------------------------------------------------------------------------
  // Operation slots, reservation and diagnostics
  // ---------------------------------------------------------------------------
  // One slot per channel; a slot frees when its drive reports completion.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      actValid_reg <= '0;
      actDrive_reg[0] <= '0;
      actDrive_reg[1] <= '0;
      resvValid_reg <= 1'b0;
      resvChan_reg <= 1'b0;
      diagCnt_reg <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
        if (actValid_reg[c] && opDone[actDrive_reg[c]])
          actValid_reg[c] <= 1'b0;
      if (take && startOp)
      begin
        actValid_reg[ch] <= 1'b1;
        actDrive_reg[ch] <= d;
      end
      if (take && resvSet)
      begin
        resvValid_reg <= 1'b1;
        resvChan_reg <= ch;
      end
      else if (take && resvClr)
        resvValid_reg <= 1'b0;
      if (take && diagStart)
        diagCnt_reg <= DIAG_W'(DIAG_LEN);
      else if (diagRunning)
        diagCnt_reg <= diagCnt_reg - 1'b1;
    end
  end

  // Sticky sense flags: a new event in the clearing cycle survives.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_reg <= '0;
      fault_reg <= '0;
      lastCmd_reg <= '0;
      lastDrv_reg <= '0;
    end
    else
    begin
      flags_reg <= ((take && senseClr) ? '0 : flags_reg) | (take ? flagSet : '0) |
                   {(diagCnt_reg == DIAG_W'(1)) && !diagPass, 3'h0};
      fault_reg <= ((take && senseClr) ? '0 : fault_reg) | measureFault;
      if (take)
      begin
        lastCmd_reg <= link.cmdCode;
        if (link.cmdCode != CMD_SENSE)
          lastDrv_reg <= d;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Answers and drive strobes
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      respValid_reg <= 1'b0;
      respStatus_reg <= ST_OK;
      respData_reg <= '0;
      driveStart <= 1'b0;
      driveSel <= '0;
      driveWrite <= 1'b0;
      driveMode <= MODE_UNSET;
      sevenCfg <= '0;
      writeIdBurst <= 1'b0;
    end
    else
    begin
      respValid_reg <= take;
      driveStart <= take && startOp;
      writeIdBurst <= take && burst;
      if (take)
      begin
        respStatus_reg <= stat;
        respData_reg <= data;
      end
      if (take && startOp)
      begin
        driveSel <= d;
        driveWrite <= (link.cmdCode == CMD_WRITE);
        driveMode <= opMode;
        sevenCfg <= seven_reg[d];
      end
    end
  end

  assign link.respValid = respValid_reg;
  assign link.respStatus = respStatus_reg;
  assign link.respData = respData_reg;
endmodule

// ---- tcm_pkg.sv ----
// Shared constants and types for the tape control unit and its channel-side host.
package tcm_pkg;
  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_DRIVES = 16;
  localparam int DRV_W = 4;
  localparam int SENSE_BYTES = 20;
  localparam int ARG_W = 8;
  localparam logic [DRV_W-1:0] BASE_DRIVES_V = 4'h8;
  localparam logic [ARG_W-1:0] SENSE_BYTES_V = 8'h14;

  // ---------------------------------------------------------------------------
  // Enumerations
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {CMD_NOP, CMD_MODE_SET, CMD_READ, CMD_WRITE,
                            CMD_RESERVE, CMD_RELEASE, CMD_SENSE, CMD_DIAG} tcm_cmd_t;
  typedef enum logic [1:0] {OPT_SINGLE, OPT_DUAL, OPT_SEVEN, OPT_NONE} tcm_opt_t;
  typedef enum logic [1:0] {MODE_UNSET, MODE_PE, MODE_NRZI9, MODE_NRZI7} tcm_mode_t;
  typedef enum logic [2:0] {ST_OK, ST_BUSY, ST_REJECT, ST_ERROR, ST_DATA} tcm_stat_t;

  // ---------------------------------------------------------------------------
  // Mode-set argument fields
  // ---------------------------------------------------------------------------
  localparam int ARG_NRZI = 0;   // 1 selects NRZI, 0 selects phase encoding.
  localparam int ARG_DENS = 1;   // Seven-track: 1 selects 800 bpi, 0 selects 556 bpi.
  localparam int ARG_PAR = 2;    // Seven-track: 1 selects odd parity.
  localparam int ARG_CONV = 3;   // Seven-track: 1 selects converter, 0 translator.
  localparam int SEVEN_W = 3;

  // ---------------------------------------------------------------------------
  // Sense byte layout
  // ---------------------------------------------------------------------------
  localparam int SNS_FLAGS = 0;
  localparam int SNS_MODE = 1;
  localparam int SNS_TRACE = 2;
  localparam int SNS_CU_SER_HI = 3;
  localparam int SNS_CU_SER_LO = 4;
  localparam int SNS_CU_OPT = 5;
  localparam int SNS_DRV_OPT = 6;
  localparam int SNS_EC_LEVEL = 7;
  localparam int SNS_FAULT_LO = 8;
  localparam int SNS_FAULT_HI = 9;
  localparam int SNS_LAST_DRV = 10;
  localparam int FLG_REJECT = 0;
  localparam int FLG_ERROR = 1;
  localparam int FLG_MODE_REJ = 2;
  localparam int FLG_DIAG_FAIL = 3;
  localparam int FLG_FAULT = 4;
  localparam int FLG_W = 4;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int DIAG_TIME_NS = 1000;
  localparam int DIAG_CYCLES = DIAG_TIME_NS / CLK_PERIOD_NS;
  localparam int DIAG_W = 12;

  // ---------------------------------------------------------------------------
  // Host register map (Wishbone byte addresses) and fields
  // ---------------------------------------------------------------------------
  localparam int WB_AW = 8;
  localparam logic [WB_AW-1:0] REG_CMD = 8'h00;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_DRV_LSB = 4;
  localparam int CMD_CHAN_BIT = 8;
  localparam int CMD_ARG_LSB = 16;
  localparam int STS_PEND_BIT = 0;
  localparam int STS_STAT_LSB = 1;
  localparam int STS_DATA_LSB = 8;
  localparam int STS_OVR_BIT = 16;
endpackage

// ---- tcm_if.sv ----
// Command link between the channel-side host and the tape control unit.
`timescale 1ns/1ps
interface tcm_if
  import tcm_pkg::*;
(
  input logic core_clk,
  input logic rstn
);
  logic cmdValid;
  logic cmdReady;
  tcm_cmd_t cmdCode;
  logic cmdChan;
  logic [DRV_W-1:0] cmdDrive;
  logic [ARG_W-1:0] cmdArg;
  logic respValid;
  tcm_stat_t respStatus;
  logic [ARG_W-1:0] respData;

  modport dev (input cmdValid, cmdCode, cmdChan, cmdDrive, cmdArg,
               output cmdReady, respValid, respStatus, respData);
  modport chan (output cmdValid, cmdCode, cmdChan, cmdDrive, cmdArg,
                input cmdReady, respValid, respStatus, respData);
endinterface

// ---- tcm_channel_host.sv ----
// Channel-side host: Wishbone registers that issue commands to the control unit.
`timescale 1ns/1ps
module tcm_channel_host
  import tcm_pkg::*;
(
  input logic core_clk,
  input logic rstn,
  tcm_if.chan link,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [WB_AW-1:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  input logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic pend_reg;
  logic sent_reg;
  logic ovr_reg;
  tcm_stat_t stat_reg;
  logic [ARG_W-1:0] data_reg;
  logic cmdValid_reg;
  tcm_cmd_t code_reg;
  logic chan_reg;
  logic [DRV_W-1:0] drv_reg;
  logic [ARG_W-1:0] arg_reg;
  logic req;
  logic cmdWr;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Partial writes to the command word are ignored, so no half command is sent.
  assign cmdWr = req && wb_we_i && wb_adr_i == REG_CMD && wb_sel_i == 4'hf;

  // Every access, mapped or not, is acknowledged one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i && wb_adr_i == REG_STATUS)
      begin
        wb_dat_o[STS_PEND_BIT] <= pend_reg;
        wb_dat_o[STS_STAT_LSB +: 3] <= stat_reg;
        wb_dat_o[STS_DATA_LSB +: ARG_W] <= data_reg;
        wb_dat_o[STS_OVR_BIT] <= ovr_reg;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Command issue
  // ---------------------------------------------------------------------------
  // Only one command is outstanding; a write while pending only sets overrun.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_reg <= 1'b0;
      sent_reg <= 1'b0;
      ovr_reg <= 1'b0;
      stat_reg <= ST_OK;
      data_reg <= '0;
      cmdValid_reg <= 1'b0;
      code_reg <= CMD_NOP;
      chan_reg <= 1'b0;
      drv_reg <= '0;
      arg_reg <= '0;
    end
    else
    begin
      if (cmdWr && pend_reg)
        ovr_reg <= 1'b1;
      else if (cmdWr)
      begin
        pend_reg <= 1'b1;
        sent_reg <= 1'b0;
        ovr_reg <= 1'b0;
        cmdValid_reg <= 1'b1;
        code_reg <= tcm_cmd_t'(wb_dat_i[CMD_CODE_LSB +: 4]);
        drv_reg <= wb_dat_i[CMD_DRV_LSB +: DRV_W];
        chan_reg <= wb_dat_i[CMD_CHAN_BIT];
        arg_reg <= wb_dat_i[CMD_ARG_LSB +: ARG_W];
      end
      if (cmdValid_reg && link.cmdReady)
      begin
        cmdValid_reg <= 1'b0;
        sent_reg <= 1'b1;
      end
      // Busy is reported; software retries, which is how a channel waits.
      if (pend_reg && sent_reg && link.respValid)
      begin
        pend_reg <= 1'b0;
        stat_reg <= link.respStatus;
        data_reg <= link.respData;
      end
    end
  end

  assign link.cmdValid = cmdValid_reg;
  assign link.cmdCode = code_reg;
  assign link.cmdChan = chan_reg;
  assign link.cmdDrive = drv_reg;
  assign link.cmdArg = arg_reg;
endmodule

// ---- tcm_checker_sva.sv ----
// Link checker for the host to control unit command path.
`timescale 1ns/1ps
module tcm_checker_sva
  import tcm_pkg::*;
#(
  parameter int DIAG_LEN = DIAG_CYCLES
)
(
  input logic core_clk,
  input logic rstn,
  input logic cmdValid,
  input logic cmdReady,
  input tcm_cmd_t cmdCode,
  input logic cmdChan,
  input logic [DRV_W-1:0] cmdDrive,
  input logic [ARG_W-1:0] cmdArg,
  input logic respValid,
  input tcm_stat_t respStatus,
  input logic [ARG_W-1:0] respData
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [3:0] lastCode_reg;
  logic lastChan_reg;
  logic resvHeld_reg;
  logic resvChan_reg;
  logic [DIAG_W-1:0] diagLeft_reg;
  wire okResp = respValid && respStatus == ST_OK;
  // -----
  // Shadow state
  // -----
  // Last taken command, to tie each answer to its cause.
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      {lastCode_reg, lastChan_reg} <= '0;
    else if (cmdValid)
      {lastCode_reg, lastChan_reg} <= {cmdCode, cmdChan};
  // Reservation holder; only a release from the holder ends it.
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      {resvHeld_reg, resvChan_reg} <= 2'b00;
    else if (okResp && lastCode_reg == CMD_RESERVE)
      {resvHeld_reg, resvChan_reg} <= {1'b1, lastChan_reg};
    else if (okResp && lastCode_reg == CMD_RELEASE && lastChan_reg == resvChan_reg)
      resvHeld_reg <= 1'b0;
  // Window three cycles short of the run, clear of edge effects.
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      diagLeft_reg <= '0;
    else if (okResp && lastCode_reg == CMD_DIAG)
      diagLeft_reg <= DIAG_W'(DIAG_LEN - 3);
    else if (diagLeft_reg != '0)
      diagLeft_reg <= diagLeft_reg - 1'b1;
  // -----
  // Properties
  // -----
  sequence s_foreign;
    cmdValid && resvHeld_reg && cmdChan != resvChan_reg;
  endsequence
  sequence s_busyAns;
    respValid && respStatus == ST_BUSY;
  endsequence
  property p_answer; cmdValid |=> respValid; endproperty
  property p_cause; respValid |-> $past(cmdValid); endproperty
  property p_ready; cmdReady; endproperty
  property p_cmdPulse; cmdValid |=> !cmdValid; endproperty
  property p_hold; !respValid |-> $stable({respStatus, respData}); endproperty
  property p_senseRej;
    cmdValid && cmdCode == CMD_SENSE && cmdArg >= SENSE_BYTES_V && !resvHeld_reg
      && diagLeft_reg == '0 |=> respValid && respStatus == ST_REJECT;
  endproperty
  property p_resv; s_foreign |=> s_busyAns; endproperty
  // Sense, reserve and release are still served while diagnostics run.
  property p_diag;
    cmdValid && cmdCode inside {CMD_MODE_SET, CMD_READ, CMD_WRITE, CMD_DIAG}
      && diagLeft_reg != '0 |=> s_busyAns;
  endproperty
  a_answer: assert property (p_answer) else $error("command left unanswered");
  a_cause: assert property (p_cause) else $error("answer without command");
  a_ready: assert property (p_ready) else $error("link not ready");
  a_cmdPulse: assert property (p_cmdPulse) else $error("command held past take");
  a_hold: assert property (p_hold) else $error("answer changed between answers");
  a_senseRej: assert property (p_senseRej) else $error("sense index not refused");
  a_resv: assert property (p_resv) else $error("reservation not exclusive");
  a_diag: assert property (p_diag) else $error("command served during diagnostics");
endmodule

// ---- test_tape_control_mode_and_path_logic.sv ----
// Bench driving the host over Wishbone against the control unit.
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin numErrors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_tape_control_mode_and_path_logic
  import tcm_pkg::*;
;
  logic core_clk = 0;
  logic rstn = 0;
  logic cyc = 0, stb = 0, we = 0, ack, diagOk = 1;
  logic [7:0] adr = 0, dt;
  logic [31:0] wdat = 0, rdat, rd;
  logic [15:0] partEn = 0, loadPt = 0, burst = 0, done = 0, fault = 0;
  logic [2:0] st;
  tcm_mode_t mode;
  tcm_opt_t cuOpt = OPT_DUAL;
  tcm_opt_t drvOpt [NUM_DRIVES];
  int numErrors = 0, testsRun = 0, cycles = 0;
  // -----
  // Clock, watchdog and instances
  // -----
  initial forever #4 core_clk = ~core_clk;
  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      numErrors++;
      giveVerdict();
    end
  end
  tcm_if tcm_if_inst (.core_clk(core_clk), .rstn(rstn));
  tcm_control_unit #(.DIAG_LEN(40)) tcm_control_unit_inst (.core_clk(core_clk), .rstn(rstn),
    .link(tcm_if_inst), .cuOption(cuOpt), .driveOption(drvOpt), .switchInstalled(1'b0),
    .communicatorInstalled(1'b0), .partitionEnable(partEn), .partitionChan(partEn),
    .atLoadPoint(loadPt), .burstSensed(burst), .opDone(done), .measureFault(fault),
    .diagPass(diagOk), .driveStart(), .driveSel(), .driveWrite(), .driveMode(mode),
    .sevenCfg(), .writeIdBurst(), .diagRunning());
  tcm_channel_host tcm_channel_host_inst (.core_clk(core_clk), .rstn(rstn), .link(tcm_if_inst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack));
  tcm_checker_sva #(.DIAG_LEN(40)) tcm_checker_sva_inst (.core_clk(core_clk), .rstn(rstn),
    .cmdValid(tcm_if_inst.cmdValid), .cmdReady(tcm_if_inst.cmdReady),
    .cmdCode(tcm_if_inst.cmdCode), .cmdChan(tcm_if_inst.cmdChan),
    .cmdDrive(tcm_if_inst.cmdDrive), .cmdArg(tcm_if_inst.cmdArg),
    .respValid(tcm_if_inst.respValid), .respStatus(tcm_if_inst.respStatus),
    .respData(tcm_if_inst.respData));
  // -----
  // Bus and command tasks
  // -----
  // One classic cycle; held until ack is seen, then released for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 0;
    stb <= 0;
    @(posedge core_clk);
  endtask
  // Issue, poll until answered, then end the drive operation.
  task automatic cmd(input tcm_cmd_t c, input logic [3:0] d, input logic ch,
                     input logic [7:0] a);
    wb(1'b1, REG_CMD, {8'h00, a, 7'h00, ch, d, c});
    do wb(1'b0, REG_STATUS, 32'h0); while (rd[STS_PEND_BIT] !== 1'b0);
    st = rd[STS_STAT_LSB +: 3];
    dt = rd[STS_DATA_LSB +: 8];
    done <= '1;
    @(posedge core_clk);
    done <= '0;
  endtask
  // -----
  // Scenarios
  // -----
  task automatic tMode();
    cmd(CMD_WRITE, 4'h0, 1'b0, 8'h00);
    `CHK("write before mode set", ST_REJECT, st)
    cmd(CMD_MODE_SET, 4'h0, 1'b0, 8'h01);
    `CHK("nrzi set on dual", ST_OK, st)
    cmd(CMD_WRITE, 4'h0, 1'b0, 8'h00);
    `CHK("nrzi write mode", MODE_NRZI9, mode)
    cuOpt <= OPT_SINGLE;
    cmd(CMD_MODE_SET, 4'h1, 1'b0, 8'h01);
    `CHK("nrzi set on single", ST_REJECT, st)
    cmd(CMD_SENSE, 4'h1, 1'b0, 8'h00);
    `CHK("mode reject flag", 1'b1, dt[FLG_MODE_REJ])
  endtask
  task automatic tRead();
    loadPt <= 16'h000e;
    burst <= 16'h0004;
    cmd(CMD_READ, 4'h1, 1'b0, 8'h00);
    `CHK("nrzi read on single", ST_ERROR, st)
    cuOpt <= OPT_DUAL;
    cmd(CMD_READ, 4'h2, 1'b0, 8'h00);
    `CHK("burst read mode", MODE_PE, mode)
    cmd(CMD_READ, 4'h3, 1'b0, 8'h00);
    `CHK("no burst dual mode", MODE_NRZI9, mode)
    loadPt <= 16'h0000;
    burst <= 16'h0008;
    cmd(CMD_READ, 4'h3, 1'b0, 8'h00);
    `CHK("mode kept off load point", MODE_NRZI9, mode)
  endtask
  task automatic tResv();
    cmd(CMD_RESERVE, 4'h0, 1'b0, 8'h00);
    `CHK("reserve", ST_OK, st)
    cmd(CMD_SENSE, 4'h0, 1'b1, 8'h00);
    `CHK("other channel busy", ST_BUSY, st)
    cmd(CMD_RELEASE, 4'h0, 1'b1, 8'h00);
    `CHK("foreign release", ST_BUSY, st)
    cmd(CMD_RELEASE, 4'h0, 1'b0, 8'h00);
    `CHK("own release", ST_OK, st)
    cmd(CMD_SENSE, 4'h0, 1'b1, 8'h07);
    `CHK("change level byte", 8'h01, dt)
  endtask
  task automatic tSense();
    cmd(CMD_SENSE, 4'h0, 1'b0, SENSE_BYTES_V);
    `CHK("index past last", ST_REJECT, st)
    cmd(CMD_SENSE, 4'h0, 1'b0, 8'h13);
    `CHK("last sense byte", 8'h00, dt)
    fault <= 16'h0020;
    @(posedge core_clk);
    fault <= 16'h0000;
    cmd(CMD_SENSE, 4'h0, 1'b0, 8'h00);
    `CHK("fault flag", 1'b1, dt[FLG_FAULT])
  endtask
  task automatic tPath();
    partEn <= 16'h0010;
    cmd(CMD_MODE_SET, 4'h4, 1'b0, 8'h00);
    `CHK("partitioned drive", ST_REJECT, st)
    cmd(CMD_MODE_SET, 4'h4, 1'b1, 8'h00);
    `CHK("owning channel", ST_OK, st)
    cmd(CMD_MODE_SET, 4'h9, 1'b0, 8'h00);
    `CHK("remote drive unswitched", ST_REJECT, st)
  endtask
  task automatic tDiag();
    diagOk <= 0;
    cmd(CMD_DIAG, 4'h0, 1'b0, 8'h00);
    `CHK("diag start", ST_OK, st)
    cmd(CMD_MODE_SET, 4'h0, 1'b0, 8'h00);
    `CHK("busy in diag", ST_BUSY, st)
    repeat (40) @(posedge core_clk);
    cmd(CMD_SENSE, 4'h0, 1'b0, 8'h00);
    `CHK("served after diag", ST_DATA, st)
    `CHK("diag fail flag", 1'b1, dt[FLG_DIAG_FAIL])
  endtask
  task automatic giveVerdict();
    if (numErrors == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Straps, reset, then each scenario.
  initial
  begin
    for (int i = 0; i < NUM_DRIVES; i++)
      drvOpt[i] = OPT_DUAL;
    drvOpt[1] = OPT_SINGLE;
    repeat (10) @(posedge core_clk);
    rstn <= 1;
    tMode();
    tRead();
    tResv();
    tSense();
    tPath();
    tDiag();
    giveVerdict();
  end
endmodule
